/* File: design/port_b_pkg.sv */
// constants and carrier types for the port b pin function multiplexer
package port_b_pkg;

    localparam int PIN_COUNT = 8;
    localparam int DATA_W    = 32;
    localparam int ADDR_W    = 8;
    localparam int SYNC_DEPTH = 2;

    // register byte addresses
    localparam logic [ADDR_W-1:0] REG_DATA_LATCH    = 8'h00;
    localparam logic [ADDR_W-1:0] REG_DIRECTION     = 8'h04;
    localparam logic [ADDR_W-1:0] REG_ANALOG_SELECT = 8'h08;
    localparam logic [ADDR_W-1:0] REG_CONTROL       = 8'h0c;
    localparam logic [ADDR_W-1:0] REG_PIN_STATUS    = 8'h10;
    localparam logic [ADDR_W-1:0] REG_DRIVE_STATUS  = 8'h14;

    // reset values: pins start as analog inputs with drivers off
    localparam logic [PIN_COUNT-1:0] LATCH_RESET     = 8'h00;
    localparam logic [PIN_COUNT-1:0] DIRECTION_RESET = 8'hff;
    localparam logic [PIN_COUNT-1:0] ANALOG_RESET    = 8'hff;

    // pins with special functions
    localparam int PIN_ZERO = 0;
    localparam int PIN_ONE  = 1;
    localparam int PIN_TWO  = 2;
    localparam int PIN_FOUR = 4;

    // control register fields, bit 3 downward
    localparam int CONTROL_W = 4;
    typedef struct packed {
        logic prog_data_sel;
        logic mp_slave;
        logic mp_master;
        logic smbus_levels;
    } control_t;
    localparam control_t CONTROL_RESET = 4'h0;

    // what the mux hands to the pads
    typedef struct packed {
        logic [PIN_COUNT-1:0] out;
        logic [PIN_COUNT-1:0] oe;
        logic [PIN_COUNT-1:0] input_enable;
    } pad_drive_t;

    // analog switch enables on the pads
    typedef struct packed {
        logic channel_five;
        logic channel_four;
        logic current_ref;
        logic current_sense;
    } analog_route_t;

endpackage

/* File: design/pin_sync.sv */
// two-flop synchroniser for a vector of pad inputs
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage_one;

    if (WIDTH < 1) begin : g_width_check
        $error("pin_sync: WIDTH must be at least 1");
    end

    // stage_one is read only by the second flop
    // pads idle high behind pull-ups; a zero here would fake a falling
    // edge on the bus data input just after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage_one <= '1;
            sync_out  <= '1;
        end else begin
            stage_one <= async_in;
            sync_out  <= stage_one;
        end
    end

endmodule // pin_sync

`default_nettype wire

/* File: design/port_b_pin_function_mux.sv */
// port b pin function multiplexer with apb register access
//
// What this block does
// - pin zero only pulls low or releases; never drives high.
// - several enabled output functions on a pin: highest priority drives.
// - analog inputs and some digital inputs work while pin is analog.
// - digital outputs still drive analog-mode pins, same priority order.
// - pad drives only when configured as output, or on pin zero for serial-bus master data; otherwise driver off.
// - pin zero: serial-bus master data beats port data; both open-drain.
// - pin zero feeds serial-bus slave data; smbus or standard thresholds.
// - converter channel four on pin one kills input buffer; reads zero.
// - pin one: multi-phase current-sense output beats port data output.
// - multi-phase slave: pin one accepts shared current reference input.
// - converter channel five on pin two reads zero; input buffer stays on.
// - pin two gives schmitt input as timer gate source two.
// - pin used as serial-programming data reads back zero.
// - analog-select set reads zero; output-enabled pin still drives.
`timescale 1ns/1ps
`default_nettype none

module port_b_pin_function_mux
    import port_b_pkg::*;
#(
    parameter int PINS = PIN_COUNT
) (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    // apb slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [ADDR_W-1:0]    paddr,
    input  wire logic [DATA_W-1:0]    pwdata,
    output var  logic [DATA_W-1:0]    prdata,
    output var  logic                 pready,
    output var  logic                 pslverr,
    // pads
    input  wire logic [PINS-1:0]      pad_in,
    output var  pad_drive_t           pad_drive,
    output var  logic                 sda_smbus_levels,
    output var  analog_route_t        analog_route,
    // serial-bus peripheral
    input  wire logic                 i2c_master_enable,
    input  wire logic                 i2c_master_sda_out,
    output var  logic                 i2c_slave_sda_in,
    // converter channel selects from the converter, same clock
    input  wire logic                 converter_channel_four,
    input  wire logic                 converter_channel_five,
    // timer gate
    output var  logic                 timer_gate_source_two
);

    if (PINS != PIN_COUNT) begin : g_pins_check
        $error("port_b_pin_function_mux: PINS must equal PIN_COUNT");
    end

    ////////////////////////////////////////////////////////////////////////
    // registers

    logic [PINS-1:0]   port_b_data_latch;
    logic [PINS-1:0]   port_b_direction;
    logic [PINS-1:0]   port_b_analog_select;
    control_t          control;

    logic [PINS-1:0]   pad_sync;
    logic [PINS-1:0]   pin_read;
    logic [PINS-1:0]   force_zero;
    logic [PINS-1:0]   next_out;
    logic [PINS-1:0]   next_oe;
    logic [PINS-1:0]   next_input_enable;
    analog_route_t     next_route;

    logic              access;
    logic              write_fire;
    logic [DATA_W-1:0] read_mux;
    logic              addr_miss;

    ////////////////////////////////////////////////////////////////////////
    // pad input synchronisers

    pin_sync #(
        .WIDTH    (PINS)
    ) u_pin_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (pad_in),
        .sync_out (pad_sync)
    );

    ////////////////////////////////////////////////////////////////////////
    // apb handshake: one wait state, so reads have a full cycle to settle

    assign access     = psel & penable;
    assign write_fire = access & pready & pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= access & ~pready;
        end
    end

    always_comb begin
        read_mux  = '0;
        addr_miss = 1'b0;
        if (paddr == REG_DATA_LATCH) begin
            read_mux[PINS-1:0] = pin_read;
        end else if (paddr == REG_DIRECTION) begin
            read_mux[PINS-1:0] = port_b_direction;
        end else if (paddr == REG_ANALOG_SELECT) begin
            read_mux[PINS-1:0] = port_b_analog_select;
        end else if (paddr == REG_CONTROL) begin
            read_mux[CONTROL_W-1:0] = control;
        end else if (paddr == REG_PIN_STATUS) begin
            read_mux[PINS-1:0] = pad_sync;
        end else if (paddr == REG_DRIVE_STATUS) begin
            read_mux[PINS-1:0] = pad_drive.oe;
        end else begin
            addr_miss = 1'b1;
        end
    end

    // answer is captured one edge before pready is seen high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= '0;
            pslverr <= 1'b0;
        end else if (access & ~pready) begin
            prdata  <= pwrite ? '0 : read_mux;
            pslverr <= addr_miss;
        end else begin
            prdata  <= '0;
            pslverr <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // software-written registers

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_b_data_latch <= LATCH_RESET;
        end else if (write_fire && paddr == REG_DATA_LATCH) begin
            port_b_data_latch <= pwdata[PINS-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_b_direction <= DIRECTION_RESET;
        end else if (write_fire && paddr == REG_DIRECTION) begin
            port_b_direction <= pwdata[PINS-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_b_analog_select <= ANALOG_RESET;
        end else if (write_fire && paddr == REG_ANALOG_SELECT) begin
            port_b_analog_select <= pwdata[PINS-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control <= CONTROL_RESET;
        end else if (write_fire && paddr == REG_CONTROL) begin
            control <= control_t'(pwdata[CONTROL_W-1:0]);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read-back forcing

    always_comb begin
        force_zero           = '0;
        force_zero[PIN_ONE]  = converter_channel_four;
        force_zero[PIN_TWO]  = converter_channel_five;
        force_zero[PIN_FOUR] = control.prog_data_sel;
    end

    // analog mode masks the digital read; read-modify-write on a driven
    // analog pin therefore writes zero back into the latch
    assign pin_read = pad_sync & ~port_b_analog_select & ~force_zero;

    ////////////////////////////////////////////////////////////////////////
    // output drivers, one per pin

    for (genvar i = 0; i < PINS; i++) begin : g_pin
        always_comb begin
            // analog select never enters the driver path
            next_out[i]          = port_b_data_latch[i];
            next_oe[i]           = ~port_b_direction[i];
            next_input_enable[i] = ~port_b_analog_select[i] & ~force_zero[i];
            if (i == PIN_ZERO) begin
                // open drain: only ever drive a low level
                next_out[i] = 1'b0;
                if (i2c_master_enable) begin
                    next_oe[i] = ~i2c_master_sda_out;
                end else begin
                    next_oe[i] = ~port_b_direction[i]
                               & ~port_b_data_latch[i];
                end
                // slave data path keeps its buffer in analog mode
                next_input_enable[i] = 1'b1;
            end else if (i == PIN_ONE) begin
                if (control.mp_master) begin
                    next_oe[i]  = 1'b0;
                    next_out[i] = 1'b0;
                end
            end else if (i == PIN_TWO) begin
                // timer gate input stays alive in analog mode
                next_input_enable[i] = 1'b1;
            end
        end
    end

    always_comb begin
        next_route               = '0;
        next_route.current_sense = control.mp_master;
        next_route.current_ref   = control.mp_slave & ~control.mp_master
                                 & port_b_analog_select[PIN_ONE];
        next_route.channel_four  = converter_channel_four
                                 & port_b_analog_select[PIN_ONE];
        next_route.channel_five  = converter_channel_five
                                 & port_b_analog_select[PIN_TWO];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pad_drive.out          <= '0;
            pad_drive.oe           <= '0;
            pad_drive.input_enable <= '0;
        end else begin
            pad_drive.out          <= next_out;
            pad_drive.oe           <= next_oe;
            pad_drive.input_enable <= next_input_enable;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            analog_route <= '0;
        end else begin
            analog_route <= next_route;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // digital inputs steered to peripherals

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            i2c_slave_sda_in      <= 1'b1;
            sda_smbus_levels      <= 1'b0;
            timer_gate_source_two <= 1'b0;
        end else begin
            i2c_slave_sda_in      <= pad_sync[PIN_ZERO];
            sda_smbus_levels      <= control.smbus_levels;
            // schmitt input threshold lives in the pad; this is its path
            timer_gate_source_two <= pad_sync[PIN_TWO];
        end
    end

endmodule // port_b_pin_function_mux

`default_nettype wire

/* File: bench/port_b_mux_chk.sv */
// assertion checker for the port b pin function multiplexer
`timescale 1ns/1ps
`default_nettype none
module port_b_mux_chk
    import port_b_pkg::*;
#(
    parameter int PINS = PIN_COUNT
) (
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    input wire logic [DATA_W-1:0] prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic [PINS-1:0]   pad_in,
    input wire pad_drive_t        pad_drive,
    input wire logic              sda_smbus_levels,
    input wire analog_route_t     analog_route,
    input wire logic              i2c_master_enable,
    input wire logic              i2c_master_sda_out,
    input wire logic              i2c_slave_sda_in,
    input wire logic              converter_channel_four,
    input wire logic              converter_channel_five,
    input wire logic              timer_gate_source_two
);
    // edges since reset; sync chain holds reset values until 3
    logic [1:0] up;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            up <= 2'h0;
        else if (up != 2'h3)
            up <= up + 2'h1;
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence setup_s; psel && !penable; endsequence
    sequence wait_s; psel && penable && !pready; endsequence
    ////////////////////////////////////////////////////////////////////
    chk_pin0_no_high: assert property (!pad_drive.out[0])
        else $error("pin zero driven high");
    chk_sda_pull_low: assert property (
        i2c_master_enable && !i2c_master_sda_out |=> pad_drive.oe[0])
        else $error("bus master low not driven");
    chk_sda_release: assert property (
        i2c_master_enable && i2c_master_sda_out |=> !pad_drive.oe[0])
        else $error("bus master release overridden");
    chk_sense_blocks: assert property (analog_route.current_sense
        |-> !pad_drive.oe[1] && !pad_drive.out[1])
        else $error("pin one driven during current sense");
    chk_ref_excl: assert property (analog_route.current_ref
        |-> !analog_route.current_sense)
        else $error("reference and sense both on");
    chk_ch4_buffer: assert property (analog_route.channel_four
        |-> !pad_drive.input_enable[1])
        else $error("pin one buffer on with channel four");
    chk_sda_follow: assert property (up == 2'h3
        |-> i2c_slave_sda_in == $past(pad_in[0], 3))
        else $error("slave data input delay wrong");
    chk_gate_follow: assert property (up == 2'h3
        |-> timer_gate_source_two == $past(pad_in[2], 3))
        else $error("timer gate delay wrong");
    chk_one_wait: assert property (setup_s ##1 wait_s |=> pready)
        else $error("ready not after one wait state");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
endmodule // port_b_mux_chk
`default_nettype wire

/* File: bench/port_b_board.sv */
// board model: external drivers and pull-up on the port b pads
`timescale 1ns/1ps
`default_nettype none
module port_b_board
    import port_b_pkg::*;
(
    input  wire logic [PIN_COUNT-1:0] ext,
    input  wire pad_drive_t           drv,
    output var  logic [PIN_COUNT-1:0] pad_in
);
    // ext[0] stands for the pull-up on the open-drain pin
    always_comb begin
        for (int i = 0; i < PIN_COUNT; i++) begin
            pad_in[i] = drv.oe[i] ? drv.out[i] : ext[i];
        end
    end
endmodule // port_b_board
`default_nettype wire

/* File: bench/tb.sv */
// self-checking bench for the port b pin function multiplexer
`timescale 1ns/1ps
`default_nettype none
module tb
    import port_b_pkg::*;
;
    logic          pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]    paddr, ext, pad_in;
    logic [31:0]   pwdata, prdata, rd;
    logic          i2c_en, i2c_sda, sda_in, conv4, conv5, gate, lvl, err;
    pad_drive_t    drv;
    analog_route_t route;
    int            bad_count, check_count;
    port_b_pin_function_mux port_b_pin_function_mux_i (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pad_in(pad_in), .pad_drive(drv),
        .sda_smbus_levels(lvl), .analog_route(route),
        .i2c_master_enable(i2c_en), .i2c_master_sda_out(i2c_sda),
        .i2c_slave_sda_in(sda_in), .converter_channel_four(conv4),
        .converter_channel_five(conv5), .timer_gate_source_two(gate));
    port_b_board port_b_board_i (.ext(ext), .drv(drv), .pad_in(pad_in));
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    ////////////////////////////////////////////////////////////////////
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // request held until the edge at which pready is seen high; the
    // answer is taken at that same edge, then the bus is released
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        cmp(rd, exp);
    endtask
    // outputs lag registers and pad inputs by up to three edges
    task automatic settle();
        repeat (4) @(posedge pclk);
        @(negedge pclk);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        settle();
        cmp(drv.oe, 8'h00);
        rc(REG_DIRECTION, 32'hff);
        $display("reset test done");
    endtask
    task automatic t_drive();
        wr(REG_DIRECTION, 32'h00);
        wr(REG_DATA_LATCH, 32'ha6);
        settle();
        cmp({drv.out, drv.oe}, 16'ha6ff);
        rc(REG_DATA_LATCH, 32'h0);
        wr(REG_DATA_LATCH, 32'ha7);
        settle();
        cmp({drv.out, drv.oe}, 16'ha6fe);
        $display("drive test done");
    endtask
    task automatic t_bus();
        @(posedge pclk);
        i2c_en <= 1'b1;
        settle();
        cmp({drv.oe[0], sda_in}, 2'b10);
        @(posedge pclk);
        i2c_sda <= 1'b1;
        wr(REG_DATA_LATCH, 32'ha6);
        settle();
        cmp({drv.oe[0], sda_in}, 2'b01);
        wr(REG_CONTROL, 32'h1);
        settle();
        cmp(lvl, 1'b1);
        $display("bus test done");
    endtask
    task automatic t_read();
        wr(REG_DIRECTION, 32'hff);
        wr(REG_ANALOG_SELECT, 32'h00);
        @(posedge pclk);
        ext <= 8'h5b;
        settle();
        rc(REG_DATA_LATCH, 32'h5b);
        cmp(gate, 1'b0);
        @(posedge pclk);
        ext <= 8'hff;
        conv4 <= 1'b1;
        conv5 <= 1'b1;
        wr(REG_CONTROL, 32'h8);
        settle();
        rc(REG_DATA_LATCH, 32'he9);
        cmp({drv.input_enable, gate}, 9'h1db);
        rc(REG_PIN_STATUS, 32'hff);
        $display("read test done");
    endtask
    task automatic t_phase();
        wr(REG_ANALOG_SELECT, 32'h06);
        wr(REG_DIRECTION, 32'h00);
        wr(REG_CONTROL, 32'h4);
        settle();
        cmp(route, 4'he);
        wr(REG_CONTROL, 32'h2);
        settle();
        cmp({route, drv.oe[1]}, 5'h1a);
        rc(8'h20, 32'h0);
        cmp(err, 1'b1);
        $display("phase test done");
    endtask
    // reset in mid-run: drivers off, registers back, no false data edge
    task automatic t_midreset();
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        cmp({drv, route, sda_in}, 32'h1);
        @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) begin
            @(negedge pclk);
            cmp(sda_in, 1'b1);
        end
        rc(REG_DIRECTION, 32'hff);
        rc(REG_ANALOG_SELECT, 32'hff);
        $display("reset again test done");
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        {presetn, psel, penable, pwrite, i2c_en, i2c_sda} = 6'h0;
        {conv4, conv5, paddr, pwdata} = '0;
        ext = 8'hff;
        bad_count = 0;
        check_count = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_drive();
        t_bus();
        t_read();
        t_phase();
        t_midreset();
        end_of_test();
    end
    initial begin
        #40000;
        bad_count++;
        $display("mismatch at %0t: timeout", $time);
        end_of_test();
    end
endmodule // tb
bind port_b_pin_function_mux port_b_mux_chk #(.PINS(PINS)) chk_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pad_in(pad_in),
    .pad_drive(pad_drive), .sda_smbus_levels(sda_smbus_levels),
    .analog_route(analog_route), .i2c_master_enable(i2c_master_enable),
    .i2c_master_sda_out(i2c_master_sda_out),
    .i2c_slave_sda_in(i2c_slave_sda_in),
    .converter_channel_four(converter_channel_four),
    .converter_channel_five(converter_channel_five),
    .timer_gate_source_two(timer_gate_source_two));
`default_nettype wire
